// ===== hps_pkg.sv
package hps_pkg;
  localparam int HPS_PORTS = 4;
  localparam int HPS_CLK_HZ = 40000000;
  localparam int HPS_FILT_NS = 200;
  localparam int HPS_FILT_CYC = (HPS_FILT_NS * (HPS_CLK_HZ / 1000000) + 999) / 1000;
  localparam int HPS_FILT_W = 4;
  localparam logic [HPS_PORTS-1:0] HPS_PWR_RST = 4'hf;
  localparam logic [3:0] HPS_MCLK_DIV = 4'h9;

  typedef enum logic [1:0]
  {
    HPS_ST_RESET = 2'h0,
    HPS_ST_RUN = 2'h1,
    HPS_ST_SUSP = 2'h3
  } hps_state_t;

  typedef struct packed
  {
    logic clk_o;
    logic clk_oe_b;
    logic io_o;
    logic io_oe_b;
  } hps_mem_pins_t;

  typedef struct packed
  {
    logic [HPS_FILT_W-1:0] cnt;
    logic flag;
  } hps_filt_t;

  typedef struct packed
  {
    hps_state_t st;
    logic gang;
    logic mem_en;
    logic [3:0] div;
    hps_mem_pins_t mem;
    logic [HPS_PORTS-1:0] pwr_n;
    logic susp;
  } hps_top_t;
endpackage : hps_pkg

// ===== hps_oc_filter.sv
`timescale 1ns/10ps
module hps_oc_filter
  import hps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic oc_n,
  output logic oc_seen
);
  hps_filt_t s_r;
  hps_filt_t s_nxt;

  // count consecutive low samples, clear on any high sample
  always_comb
  begin
    s_nxt = s_r;
    if (oc_n)
    begin
      s_nxt.cnt = '0;
      s_nxt.flag = 1'b0;
    end
    else if (s_r.cnt < HPS_FILT_W'(HPS_FILT_CYC))
    begin
      s_nxt.cnt = s_r.cnt + HPS_FILT_W'(1);
    end
    else
    begin
      s_nxt.flag = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      s_r <= '0;
    else
      s_r <= s_nxt;
  end

  assign oc_seen = s_r.flag;

  a_filter_spike: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(oc_seen) |-> $past(!oc_n, 1) && $past(!oc_n, 5))
    else $error("filter flagged a short spike");
endmodule : hps_oc_filter

// ===== hps_port_ctrl.sv
`timescale 1ns/10ps
// Notes on behaviour
// - with memory select high the serial memory pins stay released; the data pin is read only as the gang strap.
// - with memory select low the shared pins become serial memory clock and data.
// - over-current inputs are active low and filtered before use.
// - per-port mode gives each of four ports its own over-current input.
// - ganged mode accepts a report on any input; the board ties them together.
// - power controls are active-low outputs driven to both levels.
// - reset low returns all logic to its initial state.
// - suspend status is high in suspend and low in normal operation.
// - the logic runs from a single reference clock fed by an oscillator.
// - gang mode switches all power outputs together and any report turns all off.
// - per-port mode runs each power output and input independently.
// - with memory disabled the shared data pin selects gang mode.
module hps_port_ctrl
  import hps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic serial_mem_select_n,
  input wire logic serial_mem_io_i,
  input wire logic [HPS_PORTS-1:0] port_overcurrent_n,
  input wire logic [HPS_PORTS-1:0] port_power_req,
  input wire logic suspend_req,
  input wire logic mem_clock_req,
  input wire logic mem_io_drive,
  input wire logic mem_io_val,
  output logic [HPS_PORTS-1:0] port_power_on_n,
  output logic [HPS_PORTS-1:0] port_oc_status,
  output logic suspend_status,
  output logic gang_mode,
  output logic serial_mem_clock_o,
  output logic serial_mem_clock_oe_b,
  output logic serial_mem_io_o,
  output logic serial_mem_io_oe_b
);
  hps_top_t s_r;
  hps_top_t s_nxt;
  logic [HPS_PORTS-1:0] oc_seen;
  logic [HPS_PORTS-1:0] oc_r;
  logic any_oc;

  for (genvar i = 0; i < HPS_PORTS; i++)
  begin : g_filt
    hps_oc_filter u_filt
    (
      .clk(clk),
      .rst_b(rst_b),
      .oc_n(port_overcurrent_n[i]),
      .oc_seen(oc_seen[i])
    );
  end

  assign any_oc = |oc_seen;

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      oc_r <= '0;
    else
      oc_r <= oc_seen;
  end

  always_comb
  begin
    s_nxt = s_r;
    case (s_r.st)
      HPS_ST_RESET:
      begin
        s_nxt.mem_en = !serial_mem_select_n;
        s_nxt.gang = serial_mem_select_n && serial_mem_io_i;
        s_nxt.st = HPS_ST_RUN;
      end
      HPS_ST_RUN:
        if (suspend_req)
          s_nxt.st = HPS_ST_SUSP;
      HPS_ST_SUSP:
        if (!suspend_req)
          s_nxt.st = HPS_ST_RUN;
      default:
        s_nxt.st = HPS_ST_RESET;
    endcase
    s_nxt.susp = (s_nxt.st == HPS_ST_SUSP);
    if (s_r.gang)
      s_nxt.pwr_n = (port_power_req[0] && !any_oc) ? '0 : '1;
    else
      s_nxt.pwr_n = ~(port_power_req & ~oc_seen);
    // serial memory pins only live while memory is selected
    if (s_r.mem_en)
    begin
      s_nxt.div = (s_r.div == HPS_MCLK_DIV) ? 4'h0 : s_r.div + 4'h1;
      if (s_r.div == HPS_MCLK_DIV)
        s_nxt.mem.clk_o = mem_clock_req && !s_r.mem.clk_o;
      s_nxt.mem.clk_oe_b = 1'b0;
      s_nxt.mem.io_o = mem_io_val;
      s_nxt.mem.io_oe_b = !mem_io_drive;
    end
    else
    begin
      s_nxt.div = 4'h0;
      s_nxt.mem = '{clk_o: 1'b0, clk_oe_b: 1'b1, io_o: 1'b0, io_oe_b: 1'b1};
    end
  end

  // one clock domain; everything initialised by reset
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_r <= '0;
      s_r.pwr_n <= HPS_PWR_RST;
      s_r.mem <= '{clk_o: 1'b0, clk_oe_b: 1'b1, io_o: 1'b0, io_oe_b: 1'b1};
    end
    else
      s_r <= s_nxt;
  end

  assign port_power_on_n = s_r.pwr_n;
  assign port_oc_status = oc_r;
  assign suspend_status = s_r.susp;
  assign gang_mode = s_r.gang;
  assign serial_mem_clock_o = s_r.mem.clk_o;
  assign serial_mem_clock_oe_b = s_r.mem.clk_oe_b;
  assign serial_mem_io_o = s_r.mem.io_o;
  assign serial_mem_io_oe_b = s_r.mem.io_oe_b;

  sequence s_oc_any;
    s_r.gang && any_oc;
  endsequence

  a_gang_off_all: assert property (@(posedge clk) disable iff (!rst_b)
    s_oc_any |=> port_power_on_n == '1)
    else $error("ganged over-current left a port powered");
  a_gang_together: assert property (@(posedge clk) disable iff (!rst_b)
    gang_mode |-> (port_power_on_n == '1 || port_power_on_n == '0))
    else $error("ganged outputs differ");
  a_port_oc_off: assert property (@(posedge clk) disable iff (!rst_b)
    (!gang_mode && oc_seen[1]) |=> port_power_on_n[1])
    else $error("port stayed on during its over-current");
  a_port_indep: assert property (@(posedge clk) disable iff (!rst_b)
    (!gang_mode && port_power_req[2] && !oc_seen[2]) |=> !port_power_on_n[2])
    else $error("healthy port not powered");
  a_mem_off_pins: assert property (@(posedge clk) disable iff (!rst_b)
    (s_r.st != HPS_ST_RESET && serial_mem_select_n && !s_r.mem_en) |=> serial_mem_clock_oe_b && serial_mem_io_oe_b)
    else $error("memory pins driven while disabled");
  a_mem_on_clk: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.mem_en |=> !serial_mem_clock_oe_b)
    else $error("memory clock not driven");
  a_susp_level: assert property (@(posedge clk) disable iff (!rst_b)
    (s_r.st == HPS_ST_RUN && suspend_req) |=> suspend_status ##1 (suspend_status || !suspend_req))
    else $error("suspend status wrong");
  a_gang_strap: assert property (@(posedge clk) disable iff (!rst_b)
    (s_r.st == HPS_ST_RESET) |=> gang_mode == $past(serial_mem_select_n && serial_mem_io_i))
    else $error("gang strap not taken");
  a_reset_state: assert property (@(posedge clk)
    $rose(rst_b) |-> port_power_on_n == '1 && !suspend_status)
    else $error("outputs not in reset state");

  // per-port operation after the straps are taken
  sequence s_per_port;
    !gang_mode && s_r.st != HPS_ST_RESET;
  endsequence

  // ganged operation with a healthy supply
  sequence s_gang_ok;
    s_r.gang && !any_oc;
  endsequence

  // serial memory interface live
  sequence s_mem_live;
    s_r.mem_en && s_r.st != HPS_ST_RESET;
  endsequence

  a_oc_status_lag: assert property (@(posedge clk) disable iff (!rst_b)
    !$stable(oc_seen) |=> port_oc_status == $past(oc_seen))
    else $error("over-current status does not follow the filter");
  a_port0_oc_off: assert property (@(posedge clk) disable iff (!rst_b)
    s_per_port ##0 oc_seen[0] |=> port_power_on_n[0])
    else $error("port 0 stayed on during its over-current");
  a_port2_oc_off: assert property (@(posedge clk) disable iff (!rst_b)
    s_per_port ##0 oc_seen[2] |=> port_power_on_n[2])
    else $error("port 2 stayed on during its over-current");
  a_port3_oc_off: assert property (@(posedge clk) disable iff (!rst_b)
    s_per_port ##0 oc_seen[3] |=> port_power_on_n[3])
    else $error("port 3 stayed on during its over-current");
  a_port0_indep: assert property (@(posedge clk) disable iff (!rst_b)
    s_per_port ##0 (port_power_req[0] && !oc_seen[0]) |=> !port_power_on_n[0])
    else $error("healthy port 0 not powered");
  a_port1_indep: assert property (@(posedge clk) disable iff (!rst_b)
    s_per_port ##0 (port_power_req[1] && !oc_seen[1]) |=> !port_power_on_n[1])
    else $error("healthy port 1 not powered");
  a_port3_indep: assert property (@(posedge clk) disable iff (!rst_b)
    s_per_port ##0 (port_power_req[3] && !oc_seen[3]) |=> !port_power_on_n[3])
    else $error("healthy port 3 not powered");
  a_port_req_off: assert property (@(posedge clk) disable iff (!rst_b)
    s_per_port ##0 !port_power_req[1] |=> port_power_on_n[1])
    else $error("unrequested port powered");
  a_gang_on_all: assert property (@(posedge clk) disable iff (!rst_b)
    s_gang_ok ##0 port_power_req[0] |=> port_power_on_n == '0)
    else $error("ganged ports not all powered");
  a_gang_req_off: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.gang && !port_power_req[0] |=> port_power_on_n == '1)
    else $error("ganged ports powered without request");
  a_susp_clear: assert property (@(posedge clk) disable iff (!rst_b)
    (s_r.st == HPS_ST_SUSP && !suspend_req) |=> !suspend_status)
    else $error("suspend status stuck high");
  a_run_no_susp: assert property (@(posedge clk) disable iff (!rst_b)
    (s_r.st == HPS_ST_RUN && !suspend_req) |=> !suspend_status)
    else $error("suspend status high in normal operation");
  a_mem_io_drive: assert property (@(posedge clk) disable iff (!rst_b)
    s_mem_live ##0 mem_io_drive |=> !serial_mem_io_oe_b && serial_mem_io_o == $past(mem_io_val))
    else $error("memory data not driven");
  a_mem_io_free: assert property (@(posedge clk) disable iff (!rst_b)
    s_mem_live ##0 !mem_io_drive |=> serial_mem_io_oe_b)
    else $error("memory data driven while released");
  a_mem_clk_hold: assert property (@(posedge clk) disable iff (!rst_b)
    s_mem_live ##0 (s_r.div != HPS_MCLK_DIV) |=> $stable(serial_mem_clock_o))
    else $error("memory clock moved off its divider step");
  a_mem_clk_idle: assert property (@(posedge clk) disable iff (!rst_b)
    !s_r.mem_en |=> !serial_mem_clock_o)
    else $error("memory clock toggles while disabled");
  a_strap_hold: assert property (@(posedge clk) disable iff (!rst_b)
    s_r.st != HPS_ST_RESET |=> $stable(gang_mode))
    else $error("gang strap changed after reset");
  a_gang_no_mem: assert property (@(posedge clk) disable iff (!rst_b)
    gang_mode |-> !s_r.mem_en)
    else $error("gang mode taken with memory enabled");
endmodule : hps_port_ctrl

// ===== hps_pwr_switch.sv
`timescale 1ns/10ps
module hps_pwr_switch
  import hps_pkg::*;
(
  input wire logic [HPS_PORTS-1:0] fault,
  input wire logic tied,
  output logic [HPS_PORTS-1:0] port_overcurrent_n
);
  // a faulted switch pulls its flag low; tied flags share one wire
  always_comb
  begin
    if (tied)
      port_overcurrent_n = {HPS_PORTS{~|fault}};
    else
      port_overcurrent_n = ~fault;
  end
endmodule : hps_pwr_switch

// ===== test_hub_port_power_and_status_pins.sv
`timescale 1ns/10ps
module test_hub_port_power_and_status_pins
  import hps_pkg::*;
;
  typedef struct packed
  {
    logic g;
    logic [3:0] req;
    logic [3:0] flt;
    logic [3:0] pwr;
    logic [3:0] oc;
  } hps_row_t;
  hps_row_t rows [7] = '{{1'h0, 4'hf, 4'h0, 4'h0, 4'h0}, {1'h0, 4'h5, 4'h0, 4'ha, 4'h0},
    {1'h0, 4'hf, 4'h2, 4'h2, 4'h2}, {1'h0, 4'hf, 4'h9, 4'h9, 4'h9}, {1'h1, 4'h1, 4'h0, 4'h0, 4'h0},
    {1'h1, 4'h0, 4'h0, 4'hf, 4'h0}, {1'h1, 4'h1, 4'h4, 4'hf, 4'hf}};
  logic clk = 0, rst_b = 0, sel_n = 1, io_i = 0, susp_req = 0, mclk_req = 0, io_drv = 0, io_val = 0;
  logic tied = 0, v;
  logic [3:0] req = 0, fault = 0, oc_n, pwr_n, oc_st;
  logic susp, gang, mck_o, mck_oe, mio_o, mio_oe;
  int error_cnt = 0, n_compared = 0, k;
  always #12.5 clk = ~clk;
  hps_pwr_switch sw (.fault(fault), .tied(tied), .port_overcurrent_n(oc_n));
  hps_port_ctrl uut (.clk(clk), .rst_b(rst_b), .serial_mem_select_n(sel_n), .serial_mem_io_i(io_i),
    .port_overcurrent_n(oc_n), .port_power_req(req), .suspend_req(susp_req), .mem_clock_req(mclk_req),
    .mem_io_drive(io_drv), .mem_io_val(io_val), .port_power_on_n(pwr_n), .port_oc_status(oc_st),
    .suspend_status(susp), .gang_mode(gang), .serial_mem_clock_o(mck_o), .serial_mem_clock_oe_b(mck_oe),
    .serial_mem_io_o(mio_o), .serial_mem_io_oe_b(mio_oe));
  task automatic chk(input string nm, input logic [3:0] exp, input logic [3:0] got);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop
  // straps are taken at reset release, so a mode change needs a reset
  task automatic do_rst(input logic g, input logic s);
    rst_b = 0;
    io_i = g;
    sel_n = s;
    tied = g;
    repeat (5) @(posedge clk);
    #1;
    chk("reset_power", 4'hf, pwr_n);
    chk("reset_oe", 4'h3, {mck_oe, mio_oe});
    #1 rst_b = 1;
    repeat (3) @(posedge clk);
    #2;
  endtask : do_rst
  initial
  begin
    do_rst(0, 1);
    foreach (rows[i])
    begin
      if (rows[i].g !== tied)
        do_rst(rows[i].g, 1);
      req = rows[i].req;
      fault = rows[i].flt;
      repeat (14) @(posedge clk);
      #2;
      chk("gang_mode", rows[i].g, gang);
      chk("power_on_n", rows[i].pwr, pwr_n);
      chk("oc_status", rows[i].oc, oc_st);
    end
    do_rst(0, 1);
    req = 4'hf;
    fault = 4'h1;
    repeat (8) @(posedge clk);
    #2 fault = 4'h0;
    repeat (4) @(posedge clk);
    #2;
    chk("spike_oc", 4'h0, oc_st);
    chk("spike_power", 4'h0, pwr_n);
    fault = 4'h8;
    repeat (12) @(posedge clk);
    #2;
    chk("held_power", 4'h8, pwr_n);
    fault = 4'h0;
    susp_req = 1;
    @(posedge clk);
    #2;
    chk("suspend_on", 4'h1, susp);
    susp_req = 0;
    repeat (2) @(posedge clk);
    #2;
    chk("suspend_off", 4'h0, susp);
    mclk_req = 1;
    io_drv = 1;
    io_val = 1;
    repeat (25) @(posedge clk);
    #2;
    chk("mem_off_oe", 4'h3, {mck_oe, mio_oe});
    do_rst(0, 0);
    repeat (3) @(posedge clk);
    #2;
    chk("mem_on_oe", 4'h0, {mck_oe, mio_oe});
    chk("mem_io_out", 4'h1, mio_o);
    v = mck_o;
    k = 0;
    while (mck_o === v && k < 15)
    begin
      @(posedge clk);
      #2;
      k++;
    end
    chk("mem_clock_toggle", 4'h1, k < 15);
    report_and_stop();
  end
endmodule : test_hub_port_power_and_status_pins
